// *** rtl/uefs_pkg.sv ***
/*
   uefs_pkg: constants and carriers shared by the endpoint fifo/status block.
   assumes a byte-wide register port on the firmware side and a serial
   interface engine that reports packet events as one-cycle pulses.
*/
package uefs_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int EP_NUM     = 7;
   localparam int EP_W       = 3;
   localparam int FIFO_DEPTH = 64;
   localparam int CNT_W      = 11;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_EP_SELECT  = 8'hC7;
   localparam logic [7:0] OFS_EP_STATUS  = 8'hCE;
   localparam logic [7:0] OFS_FIFO_DATA  = 8'hCF;
   localparam logic [7:0] OFS_FIFO_RESET = 8'hD5;
   localparam logic [7:0] OFS_CNT_LOW    = 8'hE2;
   localparam logic [7:0] OFS_CNT_HIGH   = 8'hE3;
   localparam logic [7:0] OFS_EP_INT     = 8'hF8;

   // ------------------------------------------------------------
   // status flag positions
   // ------------------------------------------------------------
   localparam int BIT_IN_CMPL  = 0;
   localparam int BIT_OUT_B0   = 1;
   localparam int BIT_SETUP    = 2;
   localparam int BIT_STL_CRC  = 3;
   localparam int BIT_IN_RDY   = 4;
   localparam int BIT_STALL_RQ = 5;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [EP_W-1:0]  RST_SELECT     = 3'h0;
   localparam logic [7:0]       RST_FIFO_RESET = 8'h00;
   localparam logic [CNT_W-1:0] RST_COUNT      = 11'h000;
   localparam logic [7:0]       RST_RDATA      = 8'h00;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [EP_W-1:0] ep;
      logic            stall_sent;
      logic            crc_error;
      logic            setup_stored;
      logic            out_stored;
      logic            in_done;
   } uefs_sie_ev_t;

   typedef struct packed {
      logic            valid;
      logic [EP_W-1:0] ep;
      logic [7:0]      data;
   } uefs_byte_t;

endpackage

// *** rtl/uefs_fifo_mem.sv ***
/*
   uefs_fifo_mem: byte storage for all endpoint fifos, one region per endpoint.
   assumes the caller forms the address from endpoint and pointer; reads are
   combinational so the caller can register them into its own outputs.
*/
`timescale 1ns/100ps
module uefs_fifo_mem #(
   parameter int AW = 9
)
(
   input  wire logic          clk_sys,
   input  wire logic          a_we,
   input  wire logic [AW-1:0] a_addr,
   input  wire logic [7:0]    a_wdata,
   output logic      [7:0]    a_rdata,
   input  wire logic          b_we,
   input  wire logic [AW-1:0] b_addr,
   input  wire logic [7:0]    b_wdata,
   output logic      [7:0]    b_rdata
);

   // no reset: the data port has no defined value until written
   logic [7:0] mem [2**AW];

   always_ff @(posedge clk_sys) begin
      if (a_we) begin
         mem[a_addr] <= a_wdata;
      end
      // engine write last so it wins a same-address collision
      if (b_we) begin
         mem[b_addr] <= b_wdata;
      end
   end

   assign a_rdata = mem[a_addr];
   assign b_rdata = mem[b_addr];

endmodule

// *** rtl/uefs_ep_flags.sv ***
/*
   uefs_ep_flags: status flags and interrupt bit of one endpoint.
   assumes event inputs are already qualified for this endpoint and that
   the status write strobe is only high when this endpoint is selected.
*/
`timescale 1ns/100ps
module uefs_ep_flags
   import uefs_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       fifo_rst,
   input  wire logic       iso,
   input  wire logic       ev_stall,
   input  wire logic       ev_crc,
   input  wire logic       ev_setup,
   input  wire logic       ev_out,
   input  wire logic       ev_in,
   input  wire logic       fw_wr,
   input  wire logic [7:0] fw_wdata,
   output logic      [7:0] stat,
   output logic            ep_int_q
);

   logic stl_q;
   logic setup_q;
   logic outb0_q;
   logic incmpl_q;
   logic inrdy_q;
   logic stall_request_q;

   // ------------------------------------------------------------
   // flags: hardware set wins over a firmware clear in the same cycle
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset || fifo_rst) begin // RL15
         stl_q     <= 1'b0;
         setup_q   <= 1'b0;
         outb0_q   <= 1'b0;
         incmpl_q  <= 1'b0;
         inrdy_q   <= 1'b0;
         stall_request_q <= 1'b0;
      end else begin
         if (iso ? ev_crc : ev_stall) begin // RL1 RL2
            stl_q <= 1'b1;
         end else if (iso ? ev_out : (fw_wr && !fw_wdata[BIT_STL_CRC])) begin // RL2
            stl_q <= 1'b0;
         end
         if (ev_setup) begin // RL3
            setup_q <= 1'b1;
         end else if (fw_wr && !fw_wdata[BIT_SETUP]) begin
            setup_q <= 1'b0;
         end
         if (ev_out) begin // RL4
            outb0_q <= 1'b1;
         end else if (fw_wr && !fw_wdata[BIT_OUT_B0]) begin
            outb0_q <= 1'b0;
         end
         if (ev_in) begin // RL7
            incmpl_q <= 1'b1;
         end else if (fw_wr && !fw_wdata[BIT_IN_CMPL]) begin
            incmpl_q <= 1'b0;
         end
         if (fw_wr && fw_wdata[BIT_IN_RDY]) begin // RL16
            inrdy_q <= 1'b1;
         end else if (ev_in) begin
            inrdy_q <= 1'b0;
         end
         if (fw_wr) begin
            stall_request_q <= fw_wdata[BIT_STALL_RQ];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset || fifo_rst) begin
         ep_int_q <= 1'b0;
      end else begin
         ep_int_q <= stl_q || setup_q || outb0_q || incmpl_q; // RL14
      end
   end

   assign stat = {2'b00, stall_request_q, inrdy_q, stl_q, setup_q, outb0_q, incmpl_q};

   a_stall_flag_set : assert property ( // RL1
      @(posedge clk_sys) disable iff (reset)
      !iso && ev_stall && !fifo_rst |=> stl_q && stat[BIT_STL_CRC])
      else $error("stall sent did not set the flag");

   a_crc_flag_iso : assert property ( // RL2
      @(posedge clk_sys) disable iff (reset)
      iso && stl_q && fw_wr && !ev_out && !fifo_rst |=> stl_q)
      else $error("firmware cleared a read-only crc flag");

   a_setup_flag_int : assert property ( // RL3
      @(posedge clk_sys) disable iff (reset)
      ev_setup && !fifo_rst ##1 !fifo_rst |=> ep_int_q)
      else $error("setup event did not reach the interrupt bit");

   a_out_flag_set : assert property ( // RL4
      @(posedge clk_sys) disable iff (reset)
      ev_out && !fifo_rst |=> outb0_q)
      else $error("out packet did not set the bank 0 flag");

   a_in_done_flags : assert property ( // RL7
      @(posedge clk_sys) disable iff (reset)
      ev_in && !fifo_rst && !(fw_wr && fw_wdata[BIT_IN_RDY]) |=> incmpl_q && !inrdy_q)
      else $error("in completion flags wrong");

endmodule

// *** rtl/uefs_top.sv ***
/*
   uefs_top: endpoint fifo data port, received byte count and per-endpoint
   status flags of a full-speed usb device controller.
   assumes firmware uses the byte register port and the serial engine
   writes received bytes, fetches transmit bytes and pulses packet events.
*/
// Strobed register access was left to the implementer.
// ------------------------------------------------------------
// Function
// RL1: stall handshake sent sets stall/crc flag
// RL2: isochronous: same flag flags crc error, read-only
// RL3: stored setup sets flag; firmware clears after reading
// RL4: stored out packet sets bank 0 flag
// RL5: bank 0 flag set: nak further outs
// RL6: control setup may overwrite fifo despite flag
// RL7: in sent or acknowledged sets completion flag
// RL8: byte-wide fifo data port, no reset value
// RL9: select register steers port, counts and flags
// RL10: low count register: count bits 7-0
// RL11: high count register: count bits 10-8
// RL12: unused high count bits read zero
// RL13: count equals data bytes after data pid
// RL14: interrupt bit is or of sources
// RL15: firmware resets fifo before any use
// RL16: ready with empty fifo sends zero-length
// RL17: each data port access advances pointer
// ------------------------------------------------------------
`timescale 1ns/100ps
module uefs_top
   import uefs_pkg::*;
#(
   parameter int EPS   = EP_NUM,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [7:0]       reg_rdata_q,
   input  wire logic [EPS-1:0]   ep_iso,
   input  wire logic [EPS-1:0]   ep_ctrl,
   input  wire uefs_sie_ev_t     sie_ev,
   input  wire uefs_byte_t       sie_rx,
   input  wire logic             sie_tx_req,
   input  wire logic [EP_W-1:0]  sie_tx_ep,
   output logic      [7:0]       sie_tx_data_q,
   output logic      [CNT_W-1:0] sie_tx_len_q,
   output logic      [EPS-1:0]   out_nak_q,
   output logic      [EPS-1:0]   in_ready_q,
   output logic      [EPS-1:0]   stall_req_q
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam int AW    = EP_W + PTR_W;

   // fifo regions are power-of-two sized, so the address is a concatenation
   function automatic logic [AW-1:0] addr_of(input logic [EP_W-1:0] ep,
                                             input logic [PTR_W-1:0] ptr);
      return {ep, ptr};
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [EP_W-1:0]  ep_sel_q;
   logic [EPS-1:0]   fifo_rst_q;
   logic [PTR_W-1:0] fw_ptr_q   [EPS];
   logic [PTR_W-1:0] sie_ptr_q  [EPS];
   logic [CNT_W-1:0] rx_cnt_q   [EPS];
   logic [CNT_W-1:0] byte_cnt_q [EPS];
   logic [7:0]       stat       [EPS];
   logic [EPS-1:0]   ep_int;

   logic             sel_ok;
   logic             fw_acc;
   logic             wr_data;
   logic             rx_ok;
   logic [PTR_W-1:0] fw_ptr_sel;
   logic [PTR_W-1:0] fw_ptr_tx;
   logic [PTR_W-1:0] sie_ptr_rx;
   logic [PTR_W-1:0] sie_ptr_tx;
   logic [CNT_W-1:0] rx_cnt_sel;
   logic [CNT_W-1:0] byte_cnt_sel;
   logic [7:0]       stat_sel;
   logic [7:0]       mem_a_rdata;
   logic [7:0]       mem_b_rdata;
   logic [AW-1:0]    mem_b_addr;

   logic [EPS-1:0]   hit_stall;
   logic [EPS-1:0]   hit_crc;
   logic [EPS-1:0]   hit_setup;
   logic [EPS-1:0]   hit_out;
   logic [EPS-1:0]   hit_in;
   logic [EPS-1:0]   hit_pkt;
   logic [EPS-1:0]   hit_rx;
   logic [EPS-1:0]   hit_tx;
   logic [EPS-1:0]   wr_stat;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   assign sel_ok = int'(ep_sel_q) < EPS;
   // an endpoint held in fifo reset ignores the data port
   assign fw_acc = (reg_wr || reg_rd) && reg_addr == OFS_FIFO_DATA && sel_ok && !fifo_rst_q[ep_sel_q];
   assign wr_data = fw_acc && reg_wr; // RL8
   assign rx_ok = sie_rx.valid && int'(sie_rx.ep) < EPS && !fifo_rst_q[sie_rx.ep];

   always_comb begin
      for (int i = 0; i < EPS; i++) begin
         hit_stall[i] = sie_ev.stall_sent && int'(sie_ev.ep) == i;
         hit_crc[i]   = sie_ev.crc_error && int'(sie_ev.ep) == i;
         // setup only lands on control endpoints, flag or not
         hit_setup[i] = sie_ev.setup_stored && ep_ctrl[i] && int'(sie_ev.ep) == i; // RL6
         hit_out[i]   = sie_ev.out_stored && int'(sie_ev.ep) == i;
         hit_in[i]    = sie_ev.in_done && int'(sie_ev.ep) == i;
         hit_pkt[i]   = hit_setup[i] || hit_out[i] || hit_in[i];
         hit_rx[i]    = rx_ok && int'(sie_rx.ep) == i;
         hit_tx[i]    = sie_tx_req && !rx_ok && int'(sie_tx_ep) == i;
         wr_stat[i]   = reg_wr && reg_addr == OFS_EP_STATUS && int'(ep_sel_q) == i; // RL9
      end
   end

   // selection by loop keeps an out-of-range endpoint number from indexing past the arrays
   always_comb begin
      fw_ptr_sel   = '0;
      fw_ptr_tx    = '0;
      sie_ptr_rx   = '0;
      sie_ptr_tx   = '0;
      rx_cnt_sel   = RST_COUNT;
      byte_cnt_sel = RST_COUNT;
      stat_sel     = RST_RDATA;
      for (int i = 0; i < EPS; i++) begin
         if (int'(ep_sel_q) == i) begin // RL9
            fw_ptr_sel   = fw_ptr_q[i];
            rx_cnt_sel   = rx_cnt_q[i];
            byte_cnt_sel = byte_cnt_q[i];
            stat_sel     = stat[i];
         end
         if (int'(sie_tx_ep) == i) begin
            fw_ptr_tx  = fw_ptr_q[i];
            sie_ptr_tx = sie_ptr_q[i];
         end
         if (int'(sie_rx.ep) == i) begin
            sie_ptr_rx = sie_ptr_q[i];
         end
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ep_sel_q <= RST_SELECT;
      end else if (reg_wr && reg_addr == OFS_EP_SELECT) begin
         ep_sel_q <= reg_wdata[EP_W-1:0]; // RL9
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         fifo_rst_q <= EPS'(RST_FIFO_RESET);
      end else if (reg_wr && reg_addr == OFS_FIFO_RESET) begin
         fifo_rst_q <= reg_wdata[EPS-1:0]; // RL15
      end
   end

   // ------------------------------------------------------------
   // pointers and byte counts
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < EPS; i++) begin
         if (reset || fifo_rst_q[i]) begin // RL15
            fw_ptr_q[i]   <= '0;
            sie_ptr_q[i]  <= '0;
            rx_cnt_q[i]   <= RST_COUNT;
            byte_cnt_q[i] <= RST_COUNT; // RL10
         end else begin
            // a finished packet rewinds both sides to the start of the region
            if (hit_pkt[i]) begin
               fw_ptr_q[i] <= '0;
            end else if (fw_acc && int'(ep_sel_q) == i) begin
               fw_ptr_q[i] <= fw_ptr_q[i] + 1'b1; // RL17
            end
            if (hit_pkt[i]) begin
               sie_ptr_q[i] <= '0;
            end else if (hit_rx[i] || hit_tx[i]) begin
               sie_ptr_q[i] <= sie_ptr_q[i] + 1'b1;
            end
            if (hit_setup[i] || hit_out[i]) begin
               rx_cnt_q[i]   <= RST_COUNT;
               byte_cnt_q[i] <= rx_cnt_q[i]; // RL13
            end else if (hit_in[i]) begin
               rx_cnt_q[i] <= RST_COUNT;
            end else if (hit_rx[i]) begin
               rx_cnt_q[i] <= rx_cnt_q[i] + 1'b1; // RL13
            end
         end
      end
   end

   // ------------------------------------------------------------
   // fifo storage
   // ------------------------------------------------------------
   // tx fetch and rx store share port b; a valid rx byte takes the port and holds the tx pointer
   assign mem_b_addr = rx_ok ? addr_of(sie_rx.ep, sie_ptr_rx) : addr_of(sie_tx_ep, sie_ptr_tx);

   uefs_fifo_mem #(
      .AW (AW)
   ) u_mem (
      .clk_sys (clk_sys),
      .a_we    (wr_data),
      .a_addr  (addr_of(ep_sel_q, fw_ptr_sel)),
      .a_wdata (reg_wdata),
      .a_rdata (mem_a_rdata),
      .b_we    (rx_ok),
      .b_addr  (mem_b_addr),
      .b_wdata (sie_rx.data),
      .b_rdata (mem_b_rdata)
   );

   // ------------------------------------------------------------
   // per-endpoint flags
   // ------------------------------------------------------------
   for (genvar i = 0; i < EPS; i++) begin : g_ep
      uefs_ep_flags u_flags (
         .clk_sys  (clk_sys),
         .reset    (reset),
         .fifo_rst (fifo_rst_q[i]),
         .iso      (ep_iso[i]),
         .ev_stall (hit_stall[i]),
         .ev_crc   (hit_crc[i]),
         .ev_setup (hit_setup[i]),
         .ev_out   (hit_out[i]),
         .ev_in    (hit_in[i]),
         .fw_wr    (wr_stat[i]),
         .fw_wdata (reg_wdata),
         .stat     (stat[i]),
         .ep_int_q (ep_int[i])
      );

      a_nak_while_full : assert property ( // RL5
         @(posedge clk_sys) disable iff (reset)
         stat[i][BIT_OUT_B0] && !ep_iso[i] |-> out_nak_q[i])
         else $error("bank 0 full but out not refused");
   end

   // ------------------------------------------------------------
   // engine-facing outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         out_nak_q   <= '0;
         in_ready_q  <= '0;
         stall_req_q <= '0;
      end else begin
         for (int i = 0; i < EPS; i++) begin
            // refuse from the storing edge on, isochronous never refused
            out_nak_q[i]   <= !ep_iso[i] && (stat[i][BIT_OUT_B0] || hit_out[i]); // RL5
            in_ready_q[i]  <= stat[i][BIT_IN_RDY];
            stall_req_q[i] <= stat[i][BIT_STALL_RQ];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sie_tx_data_q <= RST_RDATA;
         sie_tx_len_q  <= RST_COUNT;
      end else begin
         sie_tx_data_q <= sie_tx_req ? mem_b_rdata : RST_RDATA;
         // data port accesses since the last packet, modulo 64 (pointer width); none means a zero-length packet
         sie_tx_len_q  <= CNT_W'(fw_ptr_tx); // RL16
      end
   end

   // ------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata_q <= RST_RDATA;
      end else if (reg_rd) begin
         case (reg_addr)
            OFS_EP_SELECT:  reg_rdata_q <= 8'(ep_sel_q);
            OFS_EP_STATUS:  reg_rdata_q <= stat_sel;
            OFS_FIFO_DATA:  reg_rdata_q <= fw_acc ? mem_a_rdata : RST_RDATA; // RL8
            OFS_FIFO_RESET: reg_rdata_q <= 8'(fifo_rst_q);
            OFS_CNT_LOW:    reg_rdata_q <= byte_cnt_sel[7:0]; // RL10
            OFS_CNT_HIGH:   reg_rdata_q <= 8'(byte_cnt_sel[CNT_W-1:8]); // RL11 RL12
            OFS_EP_INT:     reg_rdata_q <= 8'(ep_int); // RL14
            default:        reg_rdata_q <= RST_RDATA;
         endcase
      end else begin
         // data stand only in the cycle after the read strobe
         reg_rdata_q <= RST_RDATA;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_select_follow : assert property ( // RL9
      @(posedge clk_sys) disable iff (reset)
      reg_wr && reg_addr == OFS_EP_SELECT |=> ep_sel_q == $past(reg_wdata[EP_W-1:0]))
      else $error("endpoint select not taken");

   a_ptr_advance : assert property ( // RL17
      @(posedge clk_sys) disable iff (reset)
      fw_acc && !hit_pkt[ep_sel_q] |=> fw_ptr_sel == $past(fw_ptr_sel) + 1'b1)
      else $error("data port access did not advance pointer");

   a_count_latch : assert property ( // RL13
      @(posedge clk_sys) disable iff (reset)
      sel_ok && (hit_out[ep_sel_q] || hit_setup[ep_sel_q]) && !fifo_rst_q[ep_sel_q]
         && !(reg_wr && reg_addr == OFS_EP_SELECT)
      |=> byte_cnt_sel == $past(rx_cnt_sel) && rx_cnt_sel == RST_COUNT)
      else $error("byte count not latched from received bytes");

   a_count_low_read : assert property ( // RL10
      @(posedge clk_sys) disable iff (reset)
      reg_rd && reg_addr == OFS_CNT_LOW |=> reg_rdata_q == $past(byte_cnt_sel[7:0]))
      else $error("low count read wrong");

   a_count_high_read : assert property ( // RL11
      @(posedge clk_sys) disable iff (reset)
      reg_rd && reg_addr == OFS_CNT_HIGH
      |=> reg_rdata_q[2:0] == $past(byte_cnt_sel[10:8]) && reg_rdata_q[7:3] == 5'h0_0) // RL12
      else $error("high count read wrong");

   a_zero_length : assert property ( // RL16
      @(posedge clk_sys) disable iff (reset)
      fw_ptr_tx == '0 |=> sie_tx_len_q == RST_COUNT)
      else $error("empty fifo did not report zero length");

   a_data_late : assert property ( // RL8
      @(posedge clk_sys) disable iff (reset)
      !reg_rd |=> reg_rdata_q == RST_RDATA)
      else $error("read data outside the answer cycle");

endmodule

// *** test/uefs_host_model.sv ***
/*
   uefs_host_model: stands in for the bus host as seen through the serial engine.
   assumes the bench calls one task at a time, never two at once.
*/
`timescale 1ns/100ps
module uefs_host_model
   import uefs_pkg::*;
(
   input  wire logic [7:0]      sie_tx_data_q,
   input  wire logic            clk_sys,
   output uefs_sie_ev_t         sie_ev,
   output uefs_byte_t           sie_rx,
   output logic                 sie_tx_req,
   output logic      [EP_W-1:0] sie_tx_ep
);
   initial begin
      sie_ev = '0;
      sie_rx = '0;
      sie_tx_req = 1'b0;
      sie_tx_ep = '0;
   end
   // f is {stall, crc, setup, out, in}
   task automatic evt(input logic [2:0] e, input logic [4:0] f);
      @(posedge clk_sys) sie_ev <= {e, f};
      @(posedge clk_sys) sie_ev <= '0;
   endtask
   // idle data is inverted so a stale byte never looks valid
   task automatic pkt(input logic [2:0] e, input int n, input logic [7:0] b, input logic stp);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys) sie_rx <= {1'b1, e, 8'(b + i)};
      end
      @(posedge clk_sys) sie_rx <= {1'b0, e, ~sie_rx.data};
      evt(e, stp ? 5'b00100 : 5'b00010);
   endtask
   task automatic txep(input logic [2:0] e);
      @(posedge clk_sys) sie_tx_ep <= e;
   endtask
   task automatic fetch(output logic [7:0] d);
      @(posedge clk_sys) sie_tx_req <= 1'b1;
      @(posedge clk_sys) sie_tx_req <= 1'b0;
      #1 d = sie_tx_data_q;
   endtask
endmodule

// *** test/uefs_top_tb.sv ***
/*
   uefs_top_tb: register-level tests of the endpoint fifo and status block.
   assumes the host model drives every engine-side input.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module uefs_top_tb
   import uefs_pkg::*;
();
   logic             clk_sys = 1'b0;
   logic             reset = 1'b1;
   logic [7:0]       reg_addr = '0;
   logic [7:0]       reg_wdata = '0;
   logic             reg_wr = 1'b0;
   logic             reg_rd = 1'b0;
   logic [7:0]       reg_rdata_q;
   logic [7:0]       sie_tx_data_q;
   logic [7:0]       d;
   logic [6:0]       ep_iso = 7'h04;
   logic [6:0]       ep_ctrl = 7'h01;
   logic [6:0]       out_nak_q;
   logic [6:0]       in_ready_q;
   logic [6:0]       stall_req_q;
   logic [CNT_W-1:0] sie_tx_len_q;
   logic             sie_tx_req;
   logic [EP_W-1:0]  sie_tx_ep;
   uefs_sie_ev_t     sie_ev;
   uefs_byte_t       sie_rx;
   int               errors = 0;
   int               comparisons = 0;
   int               cycles = 0;

   always #4 clk_sys = ~clk_sys;

   uefs_top i_uefs_top (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .ep_iso(ep_iso), .ep_ctrl(ep_ctrl),
      .sie_ev(sie_ev), .sie_rx(sie_rx), .sie_tx_req(sie_tx_req), .sie_tx_ep(sie_tx_ep),
      .sie_tx_data_q(sie_tx_data_q), .sie_tx_len_q(sie_tx_len_q), .out_nak_q(out_nak_q),
      .in_ready_q(in_ready_q), .stall_req_q(stall_req_q));
   uefs_host_model i_uefs_host_model (.sie_tx_data_q(sie_tx_data_q), .clk_sys(clk_sys), .sie_ev(sie_ev),
      .sie_rx(sie_rx), .sie_tx_req(sie_tx_req), .sie_tx_ep(sie_tx_ep));

   task automatic results();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys) reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys) reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys) reg_rd <= 1'b0;
      #1 `CHK(reg_rdata_q, e)
   endtask

   // the run needs a few hundred cycles; a hang ends here
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         results();
      end
   end

   initial begin
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      rd(OFS_CNT_LOW, 8'h00);
      rd(OFS_CNT_HIGH, 8'h00);
      wr(OFS_FIFO_RESET, 8'h7F);
      wr(OFS_FIFO_RESET, 8'h00);
      wr(OFS_EP_SELECT, 8'h01);
      i_uefs_host_model.pkt(3'h1, 3, 8'hA0, 1'b0);
      rd(OFS_EP_STATUS, 8'h02);
      `CHK(out_nak_q, 7'h02)
      rd(OFS_EP_INT, 8'h02);
      rd(OFS_CNT_LOW, 8'h03);
      for (int i = 0; i < 3; i++) rd(OFS_FIFO_DATA, 8'(8'hA0 + i));
      wr(OFS_EP_STATUS, 8'h00);
      @(posedge clk_sys);
      #1 `CHK(out_nak_q, 7'h00)
      rd(OFS_EP_INT, 8'h00);
      i_uefs_host_model.evt(3'h1, 5'b10000);
      rd(OFS_EP_STATUS, 8'h08);
      wr(OFS_EP_STATUS, 8'h00);
      rd(OFS_EP_STATUS, 8'h00);
      wr(OFS_EP_STATUS, 8'h2F);
      @(posedge clk_sys);
      #1 `CHK(stall_req_q, 7'h02)
      i_uefs_host_model.evt(3'h1, 5'b00100);
      rd(OFS_EP_STATUS, 8'h20);
      wr(OFS_EP_STATUS, 8'h0F);
      @(posedge clk_sys);
      #1 `CHK(stall_req_q, 7'h00)
      wr(OFS_EP_SELECT, 8'h02);
      i_uefs_host_model.evt(3'h2, 5'b01000);
      rd(OFS_EP_STATUS, 8'h08);
      wr(OFS_EP_STATUS, 8'h00);
      rd(OFS_EP_STATUS, 8'h08);
      i_uefs_host_model.pkt(3'h2, 1, 8'hC0, 1'b0);
      rd(OFS_EP_STATUS, 8'h02);
      `CHK(out_nak_q, 7'h00)
      wr(OFS_EP_SELECT, 8'h00);
      i_uefs_host_model.pkt(3'h0, 2, 8'h10, 1'b1);
      rd(OFS_EP_STATUS, 8'h04);
      rd(OFS_FIFO_DATA, 8'h10);
      wr(OFS_EP_STATUS, 8'h00);
      i_uefs_host_model.pkt(3'h0, 1, 8'h20, 1'b0);
      i_uefs_host_model.pkt(3'h0, 3, 8'h30, 1'b1);
      rd(OFS_EP_STATUS, 8'h06);
      rd(OFS_CNT_LOW, 8'h03);
      rd(OFS_FIFO_DATA, 8'h30);
      wr(OFS_EP_SELECT, 8'h03);
      wr(OFS_FIFO_DATA, 8'h5A);
      wr(OFS_FIFO_DATA, 8'h5B);
      wr(OFS_EP_STATUS, 8'h10);
      i_uefs_host_model.txep(3'h3);
      @(posedge clk_sys);
      #1 `CHK(in_ready_q, 7'h08)
      `CHK(sie_tx_len_q, 11'h002)
      i_uefs_host_model.fetch(d);
      `CHK(d, 8'h5A)
      i_uefs_host_model.fetch(d);
      `CHK(d, 8'h5B)
      i_uefs_host_model.evt(3'h3, 5'b00001);
      rd(OFS_EP_STATUS, 8'h01);
      wr(OFS_EP_STATUS, 8'h10);
      repeat (2) @(posedge clk_sys);
      #1 `CHK(sie_tx_len_q, 11'h000)
      wr(OFS_EP_SELECT, 8'h04);
      i_uefs_host_model.pkt(3'h4, 300, 8'h00, 1'b0);
      rd(OFS_CNT_LOW, 8'h2C);
      rd(OFS_CNT_HIGH, 8'h01);
      results();
   end
endmodule
